// ### dpll_ctrl.sv
// digital loop control: ratio measurement, divide value, bandwidth, lock and input loss
`timescale 1ns/1ps
module dpll_ctrl #(
	parameter int unsigned LOSS_TICKS = dpll_pkg::LOSS_TICKS,
	parameter int unsigned SKIP_CYCLES = dpll_pkg::SKIP_CYCLES,
	parameter int unsigned LOCK_CYCLES = dpll_pkg::LOCK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic freq_ref_i,
	input wire logic out_edge_i,
	input wire logic [31:0] target_ratio_i,
	input wire logic [1:0] reference_divider_select_i,
	input wire logic skip_tolerance_enable_i,
	input wire logic output_when_unlocked_i,
	output logic internal_timing_clock_o,
	output logic [11:0] div_int_o,
	output logic dither_o,
	output logic [31:0] div_value_o,
	output logic locked_o,
	output logic clk_out_en_o,
	output logic wide_bw_o,
	output logic input_missing_o
);

	typedef enum logic [2:0] {
		DPLL_ACQ,
		DPLL_RELOCK,
		DPLL_LOCK,
		DPLL_HOLD,
		DPLL_UNLK
	} dpll_state_t;

	dpll_state_t state_q;
	dpll_state_t state_d;

	logic [dpll_pkg::RDIV_W-1:0] rdiv_q;
	logic [dpll_pkg::RDIV_W-1:0] rdiv_mask;
	logic tick_q;

	logic edge_p;
	logic [23:0] period;
	logic [23:0] gap;
	logic [11:0] out_cnt;

	logic [23:0] ref_period_q;
	logic [31:0] n_q;
	logic [32:0] err;
	logic [32:0] err_abs;
	logic [32:0] step;
	logic in_tol;
	logic glitch;
	logic missing;
	logic timeout;
	logic [3:0] settle_q;
	logic [7:0] acq_per_q;
	logic [31:0] acq_cyc_q;
	logic [31:0] skip_cyc_q;
	logic skip_ok;
	logic lock_done;
	logic acquiring;
	logic period_known;

	// internal timing clock: one tick every 1, 2, 4 or 8 mclk cycles
	always_comb begin
		unique case (reference_divider_select_i)
			dpll_pkg::RDIV_SEL_1: rdiv_mask = 3'h0;
			dpll_pkg::RDIV_SEL_2: rdiv_mask = 3'h1;
			dpll_pkg::RDIV_SEL_4: rdiv_mask = 3'h3;
			dpll_pkg::RDIV_SEL_8: rdiv_mask = 3'h7;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdiv_q <= '0;
		end else begin
			rdiv_q <= rdiv_q + 3'h1;
		end
	end

	// tick registered so a select change never makes a runt strobe
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= (rdiv_q & rdiv_mask) == rdiv_mask;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			internal_timing_clock_o <= 1'b0;
		end else begin
			internal_timing_clock_o <= tick_q;
		end
	end

	dpll_edge_mon u_mon (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.freq_ref_i(freq_ref_i),
		.out_edge_i(out_edge_i),
		.edge_o(edge_p),
		.period_o(period),
		.gap_o(gap),
		.out_cnt_o(out_cnt)
	);

	// ratio error in 12.20; positive means output runs slow
	assign err = {1'b0, target_ratio_i} - {1'b0, out_cnt, 20'h00000};
	assign err_abs = err[32] ? (~err + 33'h000000001) : err;
	assign in_tol = err_abs <= dpll_pkg::LOCK_TOL;
	assign step = wide_bw_o ? ($signed(err) >>> dpll_pkg::GAIN_WIDE)
		: ($signed(err) >>> dpll_pkg::GAIN_NARROW);

	// the all-ones sentinel after unlock is no period, so it never flags a glitch
	assign period_known = ref_period_q != 24'hFFFFFF;
	// a period under half the last one is a glitch, not a faster clock
	assign glitch = edge_p && period_known
		&& ({1'b0, period} < {2'b00, ref_period_q[23:1]});
	assign missing = gap > {ref_period_q[22:0], 1'b0};
	assign timeout = gap >= LOSS_TICKS[23:0];
	assign skip_ok = skip_cyc_q < SKIP_CYCLES;
	assign acquiring = state_q == DPLL_ACQ || state_q == DPLL_RELOCK;
	// whichever bound hits first; a slow input needs one period for loss detection
	assign lock_done = period_known && (settle_q >= dpll_pkg::LOCK_SETTLE
		|| acq_per_q >= dpll_pkg::LOCK_MAX_PERIODS[7:0]
		|| acq_cyc_q >= LOCK_CYCLES);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			DPLL_ACQ, DPLL_RELOCK: begin
				if (glitch) begin
					state_d = DPLL_ACQ;
				end else if (timeout) begin
					state_d = DPLL_UNLK;
				end else if (lock_done) begin
					state_d = DPLL_LOCK;
				end
			end
			DPLL_LOCK: begin
				if (glitch) begin
					state_d = DPLL_UNLK;
				end else if (missing) begin
					state_d = DPLL_HOLD;
				end
			end
			DPLL_HOLD: begin
				if (timeout) begin
					state_d = DPLL_UNLK;
				end else if (edge_p) begin
					if (!skip_tolerance_enable_i) begin
						state_d = DPLL_ACQ;
					end else if (skip_ok) begin
						state_d = DPLL_RELOCK;
					end else begin
						// frequency may be off here with no unlock shown
						state_d = DPLL_LOCK;
					end
				end
			end
			DPLL_UNLK: begin
				if (edge_p) begin
					state_d = DPLL_ACQ;
				end
			end
			default: begin
				state_d = DPLL_UNLK;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= DPLL_UNLK;
		end else begin
			state_q <= state_d;
		end
	end

	// reference period kept from the last edge seen outside hold and unlock, glitch or not
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ref_period_q <= 24'hFFFFFF;
		end else if (edge_p && state_q != DPLL_HOLD && state_q != DPLL_UNLK) begin
			ref_period_q <= period;
		end else if (edge_p && state_q == DPLL_UNLK) begin
			ref_period_q <= 24'hFFFFFF;
		end
	end

	// divide value integrates the ratio error; frozen while the input is gone
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			n_q <= dpll_pkg::N_RESET;
		end else if (edge_p && !glitch && ref_period_q != 24'hFFFFFF
				&& (acquiring || state_q == DPLL_LOCK)) begin
			n_q <= n_q + step[31:0];
		end
	end

	dpll_dsm u_dsm (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.n_i(n_q),
		.div_int_o(div_int_o),
		.dither_o(dither_o)
	);

	// acquisition progress counters
	always_ff @(posedge mclk_i) begin
		if (rst_i || !acquiring) begin
			settle_q <= '0;
			acq_per_q <= '0;
			acq_cyc_q <= '0;
		end else begin
			if (acq_cyc_q < LOCK_CYCLES) begin
				acq_cyc_q <= acq_cyc_q + 32'h00000001;
			end
			if (edge_p) begin
				if (acq_per_q != 8'hFF) begin
					acq_per_q <= acq_per_q + 8'h01;
				end
				if (!in_tol) begin
					settle_q <= '0;
				end else if (settle_q != 4'hF) begin
					settle_q <= settle_q + 4'h1;
				end
			end
		end
	end

	// skip window counted from entry into hold, in mclk cycles
	always_ff @(posedge mclk_i) begin
		if (rst_i || state_q != DPLL_HOLD) begin
			skip_cyc_q <= '0;
		end else if (skip_ok) begin
			skip_cyc_q <= skip_cyc_q + 32'h00000001;
		end
	end

	// status and output control, all registered
	// relock under skip and hold both report lock and keep output
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			locked_o <= 1'b0;
		end else begin
			locked_o <= state_d == DPLL_LOCK || state_d == DPLL_HOLD
				|| state_d == DPLL_RELOCK;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			clk_out_en_o <= 1'b0;
		end else begin
			clk_out_en_o <= (state_d == DPLL_ACQ || state_d == DPLL_UNLK)
				? output_when_unlocked_i : 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wide_bw_o <= 1'b1;
		end else begin
			wide_bw_o <= state_d == DPLL_ACQ || state_d == DPLL_RELOCK
				|| state_d == DPLL_UNLK;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			input_missing_o <= 1'b0;
		end else begin
			input_missing_o <= state_d == DPLL_HOLD;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			div_value_o <= dpll_pkg::N_RESET;
		end else begin
			div_value_o <= n_q;
		end
	end

endmodule : dpll_ctrl

// ### dpll_ctrl_asserts.sv
// concurrent checks on the ports of the pll input-loss control block
`timescale 1ns/1ps
module dpll_ctrl_asserts #(
	parameter int unsigned LOSS_TICKS = dpll_pkg::LOSS_TICKS
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic freq_ref_i,
	input wire logic [1:0] reference_divider_select_i,
	input wire logic internal_timing_clock_o,
	input wire logic [11:0] div_int_o,
	input wire logic dither_o,
	input wire logic [31:0] div_value_o,
	input wire logic locked_o,
	input wire logic clk_out_en_o,
	input wire logic wide_bw_o,
	input wire logic input_missing_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// hold length in mclk cycles; slowest divider gives eight per tick
	logic [31:0] hold_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i || !input_missing_o)
			hold_q <= 32'h0;
		else
			hold_q <= hold_q + 32'h1;
	end
	a_reset_state: assert property (disable iff (1'b0) rst_i |=> !locked_o && !clk_out_en_o
		&& wide_bw_o && !input_missing_o && div_value_o == dpll_pkg::N_RESET)
		else $error("reset state wrong");
	a_unlocked_wide: assert property (!locked_o |-> wide_bw_o)
		else $error("narrow bandwidth while unlocked");
	a_hold_output: assert property (input_missing_o |-> locked_o && clk_out_en_o)
		else $error("output dropped during hold");
	a_hold_entry: assert property ($rose(input_missing_o) |-> $past(locked_o))
		else $error("hold entered without lock");
	// an edge in hold may update the divide two cycles later, so skip those
	a_hold_freeze: assert property ($past(input_missing_o) && input_missing_o && !freq_ref_i
		&& !$past(freq_ref_i) |-> $stable(div_value_o)) else $error("divide moved in hold");
	a_hold_bound: assert property (hold_q <= 8 * LOSS_TICKS + 8)
		else $error("hold outlived the timeout");
	a_dither_ones: assert property ((input_missing_o && !freq_ref_i) [*3] |->
		div_int_o == div_value_o[31:20] + {11'h0, dither_o}) else $error("dither sum wrong");
	a_tick_div2: assert property (internal_timing_clock_o && reference_divider_select_i ==
		dpll_pkg::RDIV_SEL_2 |=> !internal_timing_clock_o ##1 internal_timing_clock_o)
		else $error("tick spacing wrong at two");
	a_tick_div8: assert property (internal_timing_clock_o && reference_divider_select_i ==
		dpll_pkg::RDIV_SEL_8 |=> !internal_timing_clock_o [*7] ##1 internal_timing_clock_o)
		else $error("tick spacing wrong at eight");
endmodule : dpll_ctrl_asserts
bind dpll_ctrl dpll_ctrl_asserts #(.LOSS_TICKS(LOSS_TICKS)) i_dpll_ctrl_asserts (.mclk_i,
	.rst_i, .freq_ref_i, .reference_divider_select_i, .internal_timing_clock_o, .div_int_o,
	.dither_o, .div_value_o, .locked_o, .clk_out_en_o, .wide_bw_o, .input_missing_o);

// ### dpll_dsm.sv
// first-order delta-sigma modulator dithering the integer divide ratio
`timescale 1ns/1ps
module dpll_dsm (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [31:0] n_i,
	output logic [11:0] div_int_o,
	output logic dither_o
);

	logic [dpll_pkg::FRAC_W-1:0] acc_q;
	logic [dpll_pkg::FRAC_W:0] sum;

	// carry out of the fraction accumulator: ones density equals the fraction
	assign sum = {1'b0, acc_q} + {1'b0, n_i[dpll_pkg::FRAC_W-1:0]};

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			acc_q <= '0;
			div_int_o <= 12'h001;
			dither_o <= 1'b0;
		end else if (tick_i) begin
			acc_q <= sum[dpll_pkg::FRAC_W-1:0];
			dither_o <= sum[dpll_pkg::FRAC_W];
			div_int_o <= n_i[31:dpll_pkg::FRAC_W] + {11'h000, sum[dpll_pkg::FRAC_W]};
		end
	end

endmodule : dpll_dsm

// ### dpll_edge_mon.sv
// edge detector and period, gap and output-edge counters for the reference input
`timescale 1ns/1ps
module dpll_edge_mon (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic freq_ref_i,
	input wire logic out_edge_i,
	output logic edge_o,
	output logic [23:0] period_o,
	output logic [23:0] gap_o,
	output logic [11:0] out_cnt_o
);

	logic ref_q;
	logic rise;
	logic [dpll_pkg::OCNT_W-1:0] acc_q;

	assign rise = freq_ref_i & ~ref_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ref_q <= 1'b0;
			edge_o <= 1'b0;
		end else begin
			ref_q <= freq_ref_i;
			edge_o <= rise;
		end
	end

	// gap counter on the internal timing clock, restarted by every edge
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			gap_o <= '0;
			period_o <= '0;
		end else if (rise) begin
			period_o <= gap_o;
			gap_o <= '0;
		end else if (tick_i && gap_o != 24'hFFFFFF) begin
			gap_o <= gap_o + 24'h000001;
		end
	end

	// synthesized output edges counted across one input period
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			acc_q <= '0;
			out_cnt_o <= '0;
		end else if (rise) begin
			out_cnt_o <= acc_q;
			acc_q <= {11'h000, out_edge_i};
		end else if (out_edge_i && acc_q != 12'hFFF) begin
			acc_q <= acc_q + 12'h001;
		end
	end

endmodule : dpll_edge_mon

// ### dpll_pkg.sv
// constants and timing figures for the digital pll input-loss control block
package dpll_pkg;

	// clock rate of mclk_i
	localparam int unsigned MCLK_HZ = 50_000_000;

	// ratio and divide value format: 12 integer bits, 20 fraction bits
	localparam int unsigned RATIO_W = 32;
	localparam int unsigned FRAC_W = 20;
	localparam int unsigned INT_W = 12;

	// edge monitor counter widths
	localparam int unsigned GAP_W = 24;
	localparam int unsigned OCNT_W = 12;

	// internal timing clock divider width and select codes
	localparam int unsigned RDIV_W = 3;
	localparam logic [1:0] RDIV_SEL_1 = 2'h0;
	localparam logic [1:0] RDIV_SEL_2 = 2'h1;
	localparam logic [1:0] RDIV_SEL_4 = 2'h2;
	localparam logic [1:0] RDIV_SEL_8 = 2'h3;

	// input-loss timeout in internal timing clock cycles (2^23)
	localparam int unsigned LOSS_TICKS = 8_388_608;

	// skip window, least time
	localparam int unsigned SKIP_WINDOW_MS = 20;
	localparam int unsigned SKIP_CYCLES = (SKIP_WINDOW_MS * MCLK_HZ + 999) / 1000;

	// lock acquisition bounds
	localparam int unsigned LOCK_MAX_PERIODS = 200;
	localparam int unsigned LOCK_MAX_MS = 3;
	localparam int unsigned LOCK_CYCLES = (LOCK_MAX_MS * MCLK_HZ) / 1000;

	// lock detector: error tolerance in 12.20 units and settle periods
	localparam logic [32:0] LOCK_TOL = 33'h000010000;
	localparam logic [3:0] LOCK_SETTLE = 4'h4;

	// loop gains as right shifts of the ratio error
	localparam int unsigned GAIN_WIDE = 2;
	localparam int unsigned GAIN_NARROW = 6;

	// divide value after reset: ratio of one
	localparam logic [31:0] N_RESET = 32'h00100000;

endpackage : dpll_pkg

// ### dpll_ref_src.sv
// reference clock source and output feedback edges for the pll bench
`timescale 1ns/1ps
module dpll_ref_src (
	input wire logic mclk_i,
	input wire logic run_i,
	input wire logic glitch_i,
	input wire logic [15:0] period_i,
	output logic freq_ref_o,
	output logic out_edge_o
);
	logic [15:0] cnt_q;
	logic run_s;
	logic gl_s;
	initial begin
		cnt_q = 16'h0;
		freq_ref_o = 1'b0;
		out_edge_o = 1'b0;
	end
	// period scaled down with the shortened counts; removal parks the line low
	always @(posedge mclk_i) begin
		run_s = run_i;
		gl_s = glitch_i;
		#1;
		cnt_q = (cnt_q + 16'h1 >= period_i) ? 16'h0 : cnt_q + 16'h1;
		freq_ref_o = run_s && (gl_s ? (cnt_q < 16'h4 || cnt_q == 16'h8) : cnt_q < (period_i >> 1));
		// feedback runs on: the output oscillator never stops
		out_edge_o = cnt_q == 16'h1 || cnt_q == (period_i >> 1) + 16'h1;
	end
endmodule : dpll_ref_src

// ### tb_dpll_ctrl.sv
// self-checking bench for the pll input-loss control block
`timescale 1ns/1ps
module tb_dpll_ctrl;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic glitch = 1'b0;
	logic skip = 1'b0;
	logic unl = 1'b0;
	logic [1:0] sel = 2'h0;
	logic fref, oedge, itc, dith, locked, out_en, wide, miss;
	logic [11:0] dint;
	logic [31:0] dval;
	int mismatches = 0;
	int n_compared = 0;
	always #10 mclk_i = ~mclk_i;
	dpll_ctrl #(.LOSS_TICKS(200), .SKIP_CYCLES(100), .LOCK_CYCLES(500)) i_dpll_ctrl (
		.mclk_i(mclk_i), .rst_i(rst_i), .freq_ref_i(fref), .out_edge_i(oedge),
		.target_ratio_i(32'h00200000), .reference_divider_select_i(sel),
		.skip_tolerance_enable_i(skip), .output_when_unlocked_i(unl),
		.internal_timing_clock_o(itc), .div_int_o(dint), .dither_o(dith),
		.div_value_o(dval), .locked_o(locked), .clk_out_en_o(out_en),
		.wide_bw_o(wide), .input_missing_o(miss));
	dpll_ref_src i_dpll_ref_src (.mclk_i(mclk_i), .run_i(run), .glitch_i(glitch),
		.period_i(16'h0028), .freq_ref_o(fref), .out_edge_o(oedge));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step
	task automatic wait_for(input bit m, input logic want, input int lim);
		for (int i = 0; i < lim && (m ? miss : locked) !== want; i++)
			step(1);
		if ((m ? miss : locked) !== want) begin
			check("wait", {31'h0, m ? miss : locked}, {31'h0, want});
			close_out();
		end
	endtask : wait_for
	task automatic start(input logic [1:0] s, input logic sk, input logic u);
		rst_i = 1'b1;
		run = 1'b0;
		sel = s;
		skip = sk;
		unl = u;
		step(10);
		rst_i = 1'b0;
		check("wide", {31'h0, wide}, 32'h1);
		check("div", dval, dpll_pkg::N_RESET);
	endtask : start
	task automatic lock_up(input logic sk, input logic u);
		start(2'h0, sk, u);
		run = 1'b1;
		step(100);
		check("acq out", {31'h0, out_en}, {31'h0, u});
		wait_for(1'b0, 1'b1, 700);
		check("narrow", {31'h0, wide}, 32'h0);
		check("locked div", dval, dpll_pkg::N_RESET);
		check("dint", {20'h0, dint}, {20'h0, dpll_pkg::N_RESET[31:20]});
		check("dither", {31'h0, dith}, 32'h0);
	endtask : lock_up
	task automatic t_divider;
		int n;
		for (int s = 0; s < 4; s++) begin
			start(s[1:0], 1'b0, 1'b0);
			step(2);
			n = 0;
			repeat (32) begin
				n += int'(itc === 1'b1);
				step(1);
			end
			check("ticks", n, 32 >> s);
		end
	endtask : t_divider
	task automatic t_timeout(input logic u);
		lock_up(1'b0, u);
		run = 1'b0;
		wait_for(1'b1, 1'b1, 200);
		check("hold out", {31'h0, out_en}, 32'h1);
		wait_for(1'b0, 1'b0, 300);
		check("unl out", {31'h0, out_en}, {31'h0, u});
		run = 1'b1;
		step(60);
		check("reacq", {31'h0, locked}, 32'h0);
		wait_for(1'b0, 1'b1, 700);
	endtask : t_timeout
	task automatic t_gap(input logic sk);
		int drops;
		lock_up(sk, 1'b0);
		run = 1'b0;
		step(110);
		run = 1'b1;
		drops = 0;
		repeat (200) begin
			drops += int'(locked !== 1'b1) + int'(out_en !== 1'b1);
			step(1);
		end
		check("drops", {31'h0, drops > 0}, {31'h0, !sk});
		wait_for(1'b0, 1'b1, 700);
	endtask : t_gap
	task automatic t_glitch;
		lock_up(1'b0, 1'b1);
		glitch = 1'b1;
		step(50);
		glitch = 1'b0;
		run = 1'b0;
		check("glitch", {31'h0, locked}, 32'h0);
		check("no hold", {31'h0, miss}, 32'h0);
		check("unl out", {31'h0, out_en}, 32'h1);
	endtask : t_glitch
	initial begin
		t_divider();
		t_timeout(1'b0);
		t_timeout(1'b1);
		t_gap(1'b0);
		t_gap(1'b1);
		t_glitch();
		close_out();
	end
endmodule : tb_dpll_ctrl
